/* scdg_pkg.sv */
// package: register map, field layout and reset values of the clock control slice
package scdg_pkg;
    localparam logic [15:0] SCDG_GATE_OFFSET = 16'h1040;
    localparam logic [15:0] SCDG_DIV_OFFSET = 16'h1044;
    localparam int SCDG_DMA_GATE_BIT = 8;
    localparam int SCDG_CORE_DIV_LSB = 28;
    localparam int SCDG_CORE_DIV_W = 4;
    localparam int SCDG_BUS_DIV_LSB = 16;
    localparam int SCDG_BUS_DIV_W = 3;
    localparam logic SCDG_DMA_GATE_RESET = 1'b0;
    localparam logic [3:0] SCDG_CORE_DIV_RESET = 4'h0;
    localparam logic [2:0] SCDG_BUS_DIV_RESET = 3'h1;
    localparam logic [3:0] SCDG_BOOT_DIV1 = 4'h0;
    localparam logic [3:0] SCDG_BOOT_DIV2 = 4'h1;
    localparam logic [3:0] SCDG_BOOT_DIV4 = 4'h3;
    localparam logic [3:0] SCDG_BOOT_DIV8 = 4'h7;
    localparam logic [31:0] SCDG_READ_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        SCDG_BOOT_BY1,
        SCDG_BOOT_BY2,
        SCDG_BOOT_BY4,
        SCDG_BOOT_BY8
    } scdg_boot_t;
endpackage

/* scdg_tick_if.sv */
// interface: ratio and ticks between the clock control top and a divider stage
`timescale 1ns/1ps
interface scdg_tick_if #(
    parameter int RATIO_W = 4
);
    logic tick_in;
    logic [RATIO_W-1:0] ratio;
    logic tick_out;
    modport ctrl (output tick_in, output ratio, input tick_out);
    modport stage (input tick_in, input ratio, output tick_out);
endinterface

/* scdg_div_stage.sv */
// module: tick divider stage that swaps its ratio only at a period boundary
`timescale 1ns/1ps
module scdg_div_stage #(
    parameter int RATIO_W = 4
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    scdg_tick_if.stage tk
);
    import scdg_pkg::*;

    logic [RATIO_W-1:0] cnt_q, cnt_d;
    logic [RATIO_W-1:0] ratio_q, ratio_d;
    logic wrap;

    always_comb begin
        wrap = tk.tick_in && (cnt_q == ratio_q);
        cnt_d = cnt_q;
        ratio_d = ratio_q;
        if (wrap) begin
            cnt_d = '0;
            ratio_d = tk.ratio;
        end else if (tk.tick_in) begin
            cnt_d = cnt_q + RATIO_W'(1);
        end
    end

    assign tk.tick_out = wrap;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
            ratio_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            ratio_q <= ratio_d;
        end
    end
endmodule // scdg_div_stage

/* scdg_clock_ctrl.sv */
// module: clock gate and clock divider registers with divided clock enables
// Functional notes
// - bit 8 of gate register switches the dma clock, 1 on
// - reserved bits of both registers read zero and ignore writes
// - divider register writes are dropped in very low power run
// - bits 31-28 divide source to system clock by value plus one
// - system divider loads 0000, 0001, 0011 or 0111 from boot option
// - bits 18-16 divide system clock further to bus clock, value plus one
// - bus divider resets to divide by two regardless of boot option
`timescale 1ns/1ps
module scdg_clock_ctrl
    import scdg_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [31:0] rdata_o,
    input wire logic very_low_power_run_i,
    input wire logic [1:0] low_power_boot_option_i,
    output logic dma_clk_en_o,
    output logic sys_clk_en_o,
    output logic bus_clk_en_o
);

    // ****************************************
    // boot decode
    // ****************************************
    function automatic logic [3:0] scdg_boot_code(input logic [1:0] opt);
        logic [3:0] code;
        code = SCDG_BOOT_DIV1;
        case (scdg_boot_t'(opt))
            SCDG_BOOT_BY1: code = SCDG_BOOT_DIV1;
            SCDG_BOOT_BY2: code = SCDG_BOOT_DIV2;
            SCDG_BOOT_BY4: code = SCDG_BOOT_DIV4;
            SCDG_BOOT_BY8: code = SCDG_BOOT_DIV8;
            default: code = SCDG_BOOT_DIV1;
        endcase
        return code;
    endfunction

    // ****************************************
    // decode and field helpers
    // ****************************************
    function automatic logic scdg_gate_hit(input logic [ADDR_W-1:0] addr);
        logic hit;
        hit = (addr == ADDR_W'(SCDG_GATE_OFFSET));
        return hit;
    endfunction

    function automatic logic scdg_div_hit(input logic [ADDR_W-1:0] addr);
        logic hit;
        hit = (addr == ADDR_W'(SCDG_DIV_OFFSET));
        return hit;
    endfunction

    function automatic logic [3:0] scdg_core_field(input logic [31:0] word);
        logic [3:0] field;
        field = word[SCDG_CORE_DIV_LSB +: SCDG_CORE_DIV_W];
        return field;
    endfunction

    function automatic logic [2:0] scdg_bus_field(input logic [31:0] word);
        logic [2:0] field;
        field = word[SCDG_BUS_DIV_LSB +: SCDG_BUS_DIV_W];
        return field;
    endfunction

    // reserved bits stay zero in every read word
    function automatic logic [31:0] scdg_gate_word(input logic gate);
        logic [31:0] word;
        word = SCDG_READ_ZERO;
        word[SCDG_DMA_GATE_BIT] = gate;
        return word;
    endfunction

    function automatic logic [31:0] scdg_div_word(input logic [3:0] core,
        input logic [2:0] bus);
        logic [31:0] word;
        word = SCDG_READ_ZERO;
        word[SCDG_CORE_DIV_LSB +: SCDG_CORE_DIV_W] = core;
        word[SCDG_BUS_DIV_LSB +: SCDG_BUS_DIV_W] = bus;
        return word;
    endfunction

    // ****************************************
    // bus decode
    // ****************************************
    logic gate_wr, div_wr, div_wr_ok, gate_rd, div_rd;

    // unmapped addresses select nothing: writes vanish, reads give zero
    always_comb begin
        gate_wr = 1'b0;
        div_wr = 1'b0;
        gate_rd = 1'b0;
        div_rd = 1'b0;
        if (we_i) begin
            if (scdg_gate_hit(addr_i)) begin
                gate_wr = 1'b1;
            end else if (scdg_div_hit(addr_i)) begin
                div_wr = 1'b1;
            end
        end
        if (re_i) begin
            if (scdg_gate_hit(addr_i)) begin
                gate_rd = 1'b1;
            end else if (scdg_div_hit(addr_i)) begin
                div_rd = 1'b1;
            end
        end
        div_wr_ok = div_wr && !very_low_power_run_i;
    end

    // ****************************************
    // boot load
    // ****************************************
    logic boot_done_q, boot_done_d;

    // low for the first edge after reset only: that edge loads the boot ratio
    // and drops any write, so software cannot race the boot load
    always_comb begin
        boot_done_d = 1'b1;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            boot_done_q <= 1'b0;
        end else begin
            boot_done_q <= boot_done_d;
        end
    end

    // ****************************************
    // dma clock gate
    // ****************************************
    logic dma_gate_q, dma_gate_d;

    always_comb begin
        dma_gate_d = dma_gate_q;
        if (boot_done_q && gate_wr) begin
            dma_gate_d = wdata_i[SCDG_DMA_GATE_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dma_gate_q <= SCDG_DMA_GATE_RESET;
        end else begin
            dma_gate_q <= dma_gate_d;
        end
    end

    // ****************************************
    // divider register
    // ****************************************
    logic [3:0] core_div_q, core_div_d;
    logic [2:0] bus_div_q, bus_div_d;

    // a write blocked in very low power run leaves both ratio fields as they were
    always_comb begin
        core_div_d = core_div_q;
        bus_div_d = bus_div_q;
        if (!boot_done_q) begin
            core_div_d = scdg_boot_code(low_power_boot_option_i);
        end else if (div_wr_ok) begin
            core_div_d = scdg_core_field(wdata_i);
            bus_div_d = scdg_bus_field(wdata_i);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            core_div_q <= SCDG_CORE_DIV_RESET;
            bus_div_q <= SCDG_BUS_DIV_RESET;
        end else begin
            core_div_q <= core_div_d;
            bus_div_q <= bus_div_d;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    logic [31:0] rdata_q, rdata_d;

    // answer stands one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_d = SCDG_READ_ZERO;
        if (gate_rd) begin
            rdata_d = scdg_gate_word(dma_gate_q);
        end else if (div_rd) begin
            rdata_d = scdg_div_word(core_div_q, bus_div_q);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= SCDG_READ_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // system stage
    // ****************************************
    scdg_tick_if #(.RATIO_W(SCDG_CORE_DIV_W)) sys_tk ();

    assign sys_tk.tick_in = 1'b1;
    assign sys_tk.ratio = core_div_q;

    scdg_div_stage #(.RATIO_W(SCDG_CORE_DIV_W)) u_sys_stage (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tk(sys_tk)
    );

    logic sys_en_q, sys_en_d;

    // one pulse per system period; the stage swaps ratio only on a wrap
    always_comb begin
        sys_en_d = sys_tk.tick_out;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sys_en_q <= 1'b0;
        end else begin
            sys_en_q <= sys_en_d;
        end
    end

    // ****************************************
    // bus stage
    // ****************************************
    scdg_tick_if #(.RATIO_W(SCDG_BUS_DIV_W)) bus_tk ();

    assign bus_tk.tick_in = sys_tk.tick_out;
    assign bus_tk.ratio = bus_div_q;

    scdg_div_stage #(.RATIO_W(SCDG_BUS_DIV_W)) u_bus_stage (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tk(bus_tk)
    );

    logic bus_en_q, bus_en_d;

    // aligned enables
    // registered beside the system enable, so a bus pulse always sits on a system pulse
    always_comb begin
        bus_en_d = bus_tk.tick_out;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_en_q <= 1'b0;
        end else begin
            bus_en_q <= bus_en_d;
        end
    end

    // ****************************************
    // port outputs
    // ****************************************
    assign rdata_o = rdata_q;
    assign dma_clk_en_o = dma_gate_q;
    assign sys_clk_en_o = sys_en_q;
    assign bus_clk_en_o = bus_en_q;
endmodule // scdg_clock_ctrl

/* scdg_properties.sv */
// checker: properties on the clock control ports
`timescale 1ns/1ps
module scdg_props
    import scdg_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [31:0] rdata_o,
    input wire logic very_low_power_run_i,
    input wire logic [1:0] low_power_boot_option_i,
    input wire logic dma_clk_en_o,
    input wire logic sys_clk_en_o,
    input wire logic bus_clk_en_o
);
    logic gsel, dsel, gbit;
    assign gsel = addr_i == ADDR_W'(SCDG_GATE_OFFSET);
    assign dsel = addr_i == ADDR_W'(SCDG_DIV_OFFSET);
    assign gbit = wdata_i[SCDG_DMA_GATE_BIT];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_gate_zero: assert property (re_i && gsel |=> rdata_o[31:9] == 0 && rdata_o[7:0] == 0)
        else $error("gate reserved bits set");
    a_gate_read: assert property (re_i && gsel |=> rdata_o[8] == dma_clk_en_o)
        else $error("gate bit differs from dma enable");
    a_gate_write: assert property (we_i && gsel |=> dma_clk_en_o == $past(gbit))
        else $error("dma enable not written");
    a_div_zero: assert property (re_i && dsel |=> rdata_o[27:19] == 0 && rdata_o[15:0] == 0)
        else $error("divider reserved bits set");
    a_div_write: assert property (we_i && dsel && !very_low_power_run_i ##1 re_i && dsel
        |=> rdata_o == ($past(wdata_i, 2) & 32'hF007_0000)) else $error("divider readback");
    a_bus_on_sys: assert property (bus_clk_en_o |-> sys_clk_en_o)
        else $error("bus tick off system tick");
    a_sys_ratio: assert property (sys_clk_en_o |-> ##[1:16] sys_clk_en_o)
        else $error("system tick late");
    a_bus_ratio: assert property (bus_clk_en_o |-> ##[1:128] bus_clk_en_o)
        else $error("bus tick late");
endmodule // scdg_props
bind scdg_clock_ctrl scdg_props #(.ADDR_W(ADDR_W)) props_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .very_low_power_run_i(very_low_power_run_i),
    .low_power_boot_option_i(low_power_boot_option_i), .dma_clk_en_o(dma_clk_en_o),
    .sys_clk_en_o(sys_clk_en_o), .bus_clk_en_o(bus_clk_en_o));

/* scdg_clock_ctrl_tb.sv */
// testbench: register access, boot values and tick ratios
`timescale 1ns/1ps
module scdg_clock_ctrl_tb
    import scdg_pkg::*;
;
    logic clk_i = 0, resetn_i = 0, we_i = 0, re_i = 0, very_low_power_run_i = 0;
    logic [15:0] addr_i = '0;
    logic [31:0] wdata_i = '0, rdata_o;
    logic [1:0] low_power_boot_option_i = '0;
    logic dma_clk_en_o, sys_clk_en_o, bus_clk_en_o;
    int n_mismatch = 0, comparisons = 0;
    always #12.5 clk_i = ~clk_i;
    scdg_clock_ctrl dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .very_low_power_run_i(very_low_power_run_i),
        .low_power_boot_option_i(low_power_boot_option_i), .dma_clk_en_o(dma_clk_en_o),
        .sys_clk_en_o(sys_clk_en_o), .bus_clk_en_o(bus_clk_en_o));
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask
    task automatic rd(string nm, logic [15:0] a, logic [31:0] e);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        @(negedge clk_i);
        chk(nm, rdata_o, e);
        @(posedge clk_i);
    endtask
    task automatic t_boot();
        for (int i = 0; i < 4; i++) begin
            resetn_i <= 1'b0;
            low_power_boot_option_i <= 2'(i);
            repeat (2) @(posedge clk_i);
            resetn_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rd("boot", SCDG_DIV_OFFSET, {4'((1 << i) - 1), 12'h001, 16'h0000});
        end
    endtask
    task automatic t_gate();
        wr(SCDG_GATE_OFFSET, 32'hFFFF_FFFF);
        rd("gate on", SCDG_GATE_OFFSET, 32'h0000_0100);
        @(negedge clk_i);
        chk("dma on", 32'(dma_clk_en_o), 32'h0000_0001);
        @(posedge clk_i);
        wr(SCDG_GATE_OFFSET, 32'hFFFF_FEFF);
        rd("gate off", SCDG_GATE_OFFSET, 32'h0000_0000);
        @(negedge clk_i);
        chk("dma off", 32'(dma_clk_en_o), 32'h0000_0000);
        @(posedge clk_i);
        rd("unmapped", 16'h1048, 32'h0000_0000);
    endtask
    task automatic t_div();
        int ns, nb;
        wr(SCDG_DIV_OFFSET, 32'hFFFF_FFFF);
        rd("div ones", SCDG_DIV_OFFSET, 32'hF007_0000);
        wr(SCDG_DIV_OFFSET, 32'h1003_0000);
        rd("div", SCDG_DIV_OFFSET, 32'h1003_0000);
        ns = 0;
        nb = 0;
        repeat (300) @(posedge clk_i);
        repeat (64) begin
            @(negedge clk_i);
            ns += (sys_clk_en_o === 1'b1);
            nb += (bus_clk_en_o === 1'b1);
        end
        chk("sys ticks", 32'(ns), 32'd32);
        chk("bus ticks", 32'(nb), 32'd8);
        @(posedge clk_i);
    endtask
    task automatic t_lock();
        very_low_power_run_i <= 1'b1;
        wr(SCDG_DIV_OFFSET, 32'h0000_0000);
        rd("div locked", SCDG_DIV_OFFSET, 32'h1003_0000);
        very_low_power_run_i <= 1'b0;
        wr(SCDG_DIV_OFFSET, 32'h0002_0000);
        rd("div free", SCDG_DIV_OFFSET, 32'h0002_0000);
    endtask
    task automatic results();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        t_boot();
        t_gate();
        t_div();
        t_lock();
        results();
    end
    // tests need about 10 us
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
endmodule // scdg_clock_ctrl_tb
